// ==== adm_pkg.sv ====
// Shared constants and types for the converter output control block.
// Assumes a 125 MHz register clock and a separate sample (link) clock.
`default_nettype none

package adm_pkg;

   // ----------------------------------------------------------------
   // Clock rate and timing
   // ----------------------------------------------------------------
   localparam int unsigned ACLK_MHZ         = 125;
   localparam int unsigned POWERON_DELAY_NS = 2000;
   localparam int unsigned CAL_RUN_NS       = 4000;
   // Least times round up to whole cycles
   localparam int unsigned POWERON_DELAY_CYC =
      (POWERON_DELAY_NS * ACLK_MHZ + 999) / 1000;
   localparam int unsigned CAL_RUN_CYC =
      (CAL_RUN_NS * ACLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 12;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam int unsigned CTRL_W      = 3;
   localparam logic [2:0]  CTRL_RESET  = 3'h1;

   // ----------------------------------------------------------------
   // Data path
   // ----------------------------------------------------------------
   localparam int unsigned CORES     = 2;
   localparam int unsigned WORD_W    = 8;
   localparam logic [7:0]  CODE_FLIP = 8'h80;

   typedef enum logic [2:0] {
      ST_HOLD_PD = 3'b000,
      ST_DELAY   = 3'b001,
      ST_CAL     = 3'b010,
      ST_RUN     = 3'b011,
      ST_DOWN    = 3'b100
   } adm_state_t;

   // Software control word
   typedef struct packed {
      logic dual_edge;
      logic swing_select;
      logic launch_edge_select;
   } adm_ctrl_t;

   // One core's pair of output buses
   typedef struct packed {
      logic [7:0] odd_word;
      logic [7:0] even_word;
   } adm_pair_t;

endpackage : adm_pkg

`default_nettype wire

// ==== adm_output_ctrl.sv ====
// Output demux, forwarded clock and power-down control of the converter.
// Assumes AXI4-Lite master on aclk and converter results on sample_clk.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`default_nettype none

module adm_output_ctrl (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Pins
   input  wire logic                      power_down_pin,
   input  wire logic                      cal_request_pin,
   output logic                           self_trim_active,
   output logic                           analog_enable,
   output logic                           swing_select,
   // Link side
   input  wire logic                      sample_clk,
   input  wire logic [adm_pkg::CORES-1:0][7:0] core_result,
   output adm_pkg::adm_pair_t [adm_pkg::CORES-1:0] data_bus,
   output logic                           data_bus_oe,
   output logic                           forwarded_clock,
   output logic                           forwarded_clock_n
);

   // ----------------------------------------------------------------
   // Pin synchronisers (register domain)
   // ----------------------------------------------------------------
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic       cal_last;
   wire        pd_level = pin_sync[0];
   wire        cal_rise = pin_sync[1] & ~cal_last;

   // Two flops per pin, edge detect reads only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         cal_last <= 1'b0;
      end else begin
         pin_meta <= {cal_request_pin, power_down_pin};
         pin_sync <= pin_meta;
         cal_last <= pin_sync[1];
      end
   end

   // ----------------------------------------------------------------
   // Calibration and power-down sequencer
   // ----------------------------------------------------------------
   adm_pkg::adm_state_t state;
   adm_pkg::adm_state_t next_state;
   logic [adm_pkg::CNT_W-1:0] cnt;
   logic [adm_pkg::CNT_W-1:0] next_cnt;

   localparam logic [adm_pkg::CNT_W-1:0] DELAY_LAST =
      adm_pkg::CNT_W'(adm_pkg::POWERON_DELAY_CYC - 1);
   localparam logic [adm_pkg::CNT_W-1:0] CAL_LAST =
      adm_pkg::CNT_W'(adm_pkg::CAL_RUN_CYC - 1);
   localparam logic [adm_pkg::CNT_W-1:0] CNT_ZERO = '0;

   // Next-state decode
   always_comb begin
      next_state = state;
      next_cnt   = cnt + 1'b1;
      case (state)
         adm_pkg::ST_HOLD_PD: begin
            next_cnt = CNT_ZERO;
            if (!pd_level) begin
               next_state = adm_pkg::ST_DELAY;
            end
         end
         // Delay counter runs only with pd low
         adm_pkg::ST_DELAY: begin
            if (pd_level) begin
               next_state = adm_pkg::ST_HOLD_PD;
               next_cnt   = CNT_ZERO;
            end else if (cnt == DELAY_LAST) begin
               next_state = adm_pkg::ST_CAL;
               next_cnt   = CNT_ZERO;
            end
         end
         adm_pkg::ST_CAL: begin
            if (cnt == CAL_LAST) begin
               next_cnt   = CNT_ZERO;
               next_state = pd_level ? adm_pkg::ST_DOWN
                                     : adm_pkg::ST_RUN;
            end
         end
         adm_pkg::ST_RUN: begin
            next_cnt = CNT_ZERO;
            if (pd_level) begin
               next_state = adm_pkg::ST_DOWN;
            end else if (cal_rise) begin
               next_state = adm_pkg::ST_CAL;
            end
         end
         adm_pkg::ST_DOWN: begin
            next_cnt = CNT_ZERO;
            if (!pd_level) begin
               next_state = adm_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = adm_pkg::ST_HOLD_PD;
            next_cnt   = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= adm_pkg::ST_HOLD_PD;
         cnt   <= CNT_ZERO;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Outputs from flops; analog held off in reset and power-down
   logic powered_down;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         self_trim_active <= 1'b0;
         powered_down     <= 1'b1;
         analog_enable    <= 1'b0;
      end else begin
         self_trim_active <= (next_state == adm_pkg::ST_CAL);
         powered_down     <= (next_state == adm_pkg::ST_DOWN) ||
                             (next_state == adm_pkg::ST_HOLD_PD);
         analog_enable    <= (next_state != adm_pkg::ST_DOWN) &&
                             (next_state != adm_pkg::ST_HOLD_PD);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   adm_pkg::adm_ctrl_t ctrl;
   logic [7:0] aw_addr;
   logic       aw_held;
   logic [7:0] w_byte;
   logic       w_strb0;
   logic       w_held;

   wire aw_take   = s_axi_awvalid & s_axi_awready;
   wire w_take    = s_axi_wvalid & s_axi_wready;
   wire do_write  = aw_held & w_held & ~s_axi_bvalid;
   wire wr_ctrl   = (aw_addr == adm_pkg::ADDR_CTRL);
   wire wr_status = (aw_addr == adm_pkg::ADDR_STATUS);
   wire ar_take   = s_axi_arvalid & s_axi_arready;
   wire rd_ctrl   = (s_axi_araddr == adm_pkg::ADDR_CTRL);
   wire rd_status = (s_axi_araddr == adm_pkg::ADDR_STATUS);

   // Address and data taken in either order, one write at a time
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire [31:0] rd_word =
      rd_ctrl   ? {{(32-adm_pkg::CTRL_W){1'b0}}, ctrl} :
      rd_status ? {27'h0, state, powered_down, self_trim_active} :
                  32'h0;

   // Write channel capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_byte       <= 8'h00;
         w_strb0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= adm_pkg::RESP_OKAY;
         ctrl         <= adm_pkg::CTRL_RESET;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_strb0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ctrl | wr_status) ? adm_pkg::RESP_OKAY
                                                  : adm_pkg::RESP_SLVERR;
            if (wr_ctrl && w_strb0) begin
               ctrl <= w_byte[adm_pkg::CTRL_W-1:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel; status is read-only, unmapped answers SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= adm_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= (rd_ctrl | rd_status) ? adm_pkg::RESP_OKAY
                                               : adm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign swing_select = ctrl.swing_select;

   // ----------------------------------------------------------------
   // Crossing into the sample clock domain
   // ----------------------------------------------------------------
   // Levels only: control bits change rarely, so per-bit sync suffices
   localparam int unsigned XS_W = adm_pkg::CTRL_W + 2;
   logic [XS_W-1:0] xs_meta;
   logic [XS_W-1:0] xs_sync;
   wire  [XS_W-1:0] xs_src = {aresetn, powered_down, ctrl};

   always_ff @(posedge sample_clk) begin
      xs_meta <= xs_src;
      xs_sync <= xs_meta;
   end

   adm_pkg::adm_ctrl_t lctrl;
   wire lrst_n = xs_sync[XS_W-1];
   wire lpd    = xs_sync[XS_W-2];
   assign lctrl = xs_sync[adm_pkg::CTRL_W-1:0];

   // ----------------------------------------------------------------
   // Demux and forwarded clock (sample clock domain)
   // ----------------------------------------------------------------
   logic       odd_slot;   // Next result belongs to the odd bus
   logic       launch;     // Word launch cycle, every second sample
   logic       fclk;
   logic [adm_pkg::CORES-1:0][7:0] odd_hold;
   logic [adm_pkg::CORES-1:0][7:0] even_hold;

   always_ff @(posedge sample_clk) begin
      if (!lrst_n) begin
         odd_slot <= 1'b1;
         launch   <= 1'b0;
      end else begin
         odd_slot <= ~odd_slot;
         launch   <= ~odd_slot;
      end
   end

   genvar c;
   generate
      for (c = 0; c < adm_pkg::CORES; c++) begin : g_core
         always_ff @(posedge sample_clk) begin
            if (!lrst_n) begin
               odd_hold[c]            <= 8'h00;
               even_hold[c]           <= 8'h00;
               data_bus[c].odd_word   <= 8'h00;
               data_bus[c].even_word  <= 8'h00;
            end else begin
               if (odd_slot) begin
                  odd_hold[c] <= core_result[c] ^ adm_pkg::CODE_FLIP;
               end else begin
                  even_hold[c] <= core_result[c] ^ adm_pkg::CODE_FLIP;
               end
               if (launch) begin
                  data_bus[c].odd_word  <= odd_hold[c];
                  data_bus[c].even_word <= even_hold[c];
               end
            end
         end
      end
   endgenerate

   // Clock form held across each idle/launch pair: a mode change landing
   // on the launch cycle would move the data without a clock edge
   adm_pkg::adm_ctrl_t lmode;
   adm_pkg::adm_ctrl_t fmode;
   assign fmode = launch ? lmode : lctrl;

   // Mode for the coming launch taken on the idle cycle
   always_ff @(posedge sample_clk) begin
      if (!lrst_n) begin
         lmode <= adm_pkg::CTRL_RESET;
      end else if (!launch) begin
         lmode <= lctrl;
      end
   end

   // Forwarded clock edge sits on the launch cycle
   always_ff @(posedge sample_clk) begin
      if (!lrst_n) begin
         fclk <= 1'b0;
      end else if (fmode.dual_edge) begin
         if (launch) begin
            fclk <= ~fclk;
         end
      end else if (launch) begin
         fclk <= fmode.launch_edge_select;
      end else begin
         fclk <= ~fmode.launch_edge_select;
      end
   end

   // single clock pair for all buses
   assign forwarded_clock   = fclk;
   assign forwarded_clock_n = ~fclk;

   always_ff @(posedge sample_clk) begin
      if (!lrst_n) begin
         data_bus_oe <= 1'b0;
      end else begin
         data_bus_oe <= ~lpd;
      end
   end

endmodule : adm_output_ctrl

`default_nettype wire

// ==== adm_output_ctrl_assertions.sv ====
// Checker for the converter output control block.
// Sees only top-level ports; attached by the bind at the foot.
`default_nettype none
module adm_output_ctrl_assertions (
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          s_axi_arready,
   input wire logic [1:0]    s_axi_bresp,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_bready,
   input wire logic [31:0]   s_axi_rdata,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_rready,
   input wire logic          self_trim_active,
   input wire logic          analog_enable,
   input wire logic          sample_clk,
   input wire adm_pkg::adm_pair_t [adm_pkg::CORES-1:0] data_bus,
   input wire logic          forwarded_clock
);
   // ----------------------------
   // Helper logic
   // ----------------------------
   logic [9:0] trim_cnt;
   // Cycles spent in the current calibration
   always_ff @(posedge aclk) begin
      if (!aresetn || !self_trim_active) trim_cnt <= 10'h000;
      else trim_cnt <= trim_cnt + 10'h001;
   end
   // A new word pair launched on the buses
   sequence s_new_word;
      $changed(data_bus);
   endsequence
   // ----------------------------
   // Register clock domain
   // ----------------------------
   a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_trim_length: assert property (@(posedge aclk)
      disable iff (!aresetn) $fell(self_trim_active) |->
      trim_cnt == 10'(adm_pkg::CAL_RUN_CYC)) else $error("trim length");
   a_trim_needs_run: assert property (@(posedge aclk)
      disable iff (!aresetn) $rose(self_trim_active) |-> $past(analog_enable))
      else $error("trim began while down");
   a_trim_stays_up: assert property (@(posedge aclk)
      disable iff (!aresetn) self_trim_active |-> analog_enable)
      else $error("down during trim");
   // ----------------------------
   // Sample clock domain
   // ----------------------------
   a_words_stand: assert property (@(posedge sample_clk)
      disable iff (!aresetn) s_new_word |=> $stable(data_bus))
      else $error("word stood one cycle");
   a_launch_clock: assert property (@(posedge sample_clk)
      disable iff (!aresetn) s_new_word |-> $changed(forwarded_clock))
      else $error("data moved without clock edge");
endmodule : adm_output_ctrl_assertions

bind adm_output_ctrl adm_output_ctrl_assertions i_adm_output_ctrl_assertions (
   .aclk, .aresetn, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .self_trim_active, .analog_enable, .sample_clk, .data_bus,
   .forwarded_clock);
`default_nettype wire

// ==== adm_capture_model.sv ====
// Receiving capture logic at the far end of the data buses.
// Assumes the bench tells it the launch edge and clock form.
`default_nettype none
module adm_capture_model #(
   parameter int FLUSH = 4
) (
   input  wire logic                     forwarded_clock,
   input  wire adm_pkg::adm_pair_t [1:0] data_bus,
   input  wire logic                     data_bus_oe,
   input  wire logic                     launch_edge_select,
   input  wire logic                     dual_edge,
   output logic [1:0][1:0][7:0]          word
);
   timeunit 1ns;
   timeprecision 1ns;
   int flush;
   // ----------------------------
   // Capture
   // ----------------------------
   // discard, capture, interleave
   always @(forwarded_clock or negedge data_bus_oe) begin
      // Words move with the clock edge; let them settle before capture
      #2;
      if (!data_bus_oe) flush = 0;
      else if (dual_edge || forwarded_clock != launch_edge_select) begin
         // Stale pipeline words are dropped first
         if (flush < FLUSH) flush++;
         else for (int c = 0; c < 2; c++)
            word[c] = {data_bus[c].even_word, data_bus[c].odd_word} ^ 16'h8080;
      end
   end
endmodule : adm_capture_model
`default_nettype wire

// ==== adm_output_ctrl_tb_top.sv ====
// Self-checking bench for the converter output control block.
// Drives AXI4-Lite, pins and converter results; models the capture side.
`default_nettype none
module adm_output_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [2:0]  c;
      logic [15:0] r;
      logic [31:0] e;
   } adm_row_t;
   logic        aclk = 1'b0, aresetn = 1'b0, sample_clk = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, cnt_on = 1'b0, lvl, fc;
   logic        power_down_pin = 1'b0, cal_request_pin = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, self_trim_active;
   logic        analog_enable, swing_select, data_bus_oe;
   logic        forwarded_clock, forwarded_clock_n;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0]  ctrl = 3'h1;
   logic [15:0] fixed = 16'h0;
   logic [1:0][7:0]          core_result = 16'h0;
   logic [1:0][1:0][7:0]     word;
   adm_pkg::adm_pair_t [1:0] data_bus, pb;
   int          failures = 0, comparisons = 0, gap = 0, run = 0;
   adm_row_t    rows [4] = '{'{3'h0, 16'h807f, 32'h0000ffff},
      '{3'h3, 16'hff00, 32'h7f7f8080}, '{3'h6, 16'h7f80, 32'hffff0000},
      '{3'h5, 16'hfe01, 32'h7e7e8181}};
   logic [2:0]  modes [4] = '{3'h0, 3'h1, 3'h4, 3'h5};

   adm_output_ctrl i_adm_output_ctrl (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .power_down_pin, .cal_request_pin, .self_trim_active,
      .analog_enable, .swing_select, .sample_clk, .core_result,
      .data_bus, .data_bus_oe, .forwarded_clock, .forwarded_clock_n);
   adm_capture_model i_adm_capture_model (.forwarded_clock, .data_bus,
      .data_bus_oe, .launch_edge_select(ctrl[0]), .dual_edge(ctrl[2]),
      .word);

   // ----------------------------
   // Clocks and stimulus
   // ----------------------------
   always #4 aclk = ~aclk;
   // Offset keeps sample edges off register edges
   initial begin
      #3;
      forever #32 sample_clk = ~sample_clk;
   end
   // Fixed codes, or a count with core 1 ahead by 8'h40
   always @(posedge sample_clk) begin
      core_result <= cnt_on ?
         {core_result[0] + 8'h41, core_result[0] + 8'h01} : fixed;
   end
   // Clock level at each launch and sample cycles between clock edges
   always @(negedge sample_clk) begin
      if (data_bus !== pb) lvl = forwarded_clock;
      if (forwarded_clock !== fc) begin
         gap = run;
         run = 1;
      end else run++;
      pb = data_bus;
      fc = forwarded_clock;
   end
   // ----------------------------
   // Tasks
   // ----------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {d, rsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic st(input logic [31:0] e);
      rd(8'h04);
      chk(d, e);
   endtask : st
   task automatic complete_run;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   // Watchdog: the whole run needs about 44 us
   initial begin
      #200000;
      failures++;
      complete_run;
   end
   // ----------------------------
   // Main sequence
   // ----------------------------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (800) @(posedge aclk);
      st(32'h0000000c);
      foreach (rows[i]) begin
         {ctrl, fixed} <= {rows[i].c, rows[i].r};
         wr(8'h00, {29'h0, rows[i].c});
         chk(rsp, 32'h0);
         rd(8'h00);
         chk(d, {29'h0, rows[i].c});
         repeat (240) @(posedge aclk);
         chk(swing_select, rows[i].c[1]);
         chk(data_bus, rows[i].e);
         chk(data_bus_oe, 1'b1);
      end
      // Running count: pairing, launch edge, clock form
      cnt_on <= 1'b1;
      foreach (modes[i]) begin
         ctrl <= modes[i];
         wr(8'h00, {29'h0, modes[i]});
         repeat (240) @(posedge aclk);
         chk(8'(word[0][1] - word[0][0]), 8'h01);
         chk(8'(word[1][0] - word[0][0]), 8'h40);
         chk(gap, modes[i][2] ? 2 : 1);
         chk(forwarded_clock_n, !forwarded_clock);
         if (!modes[i][2]) chk(lvl, modes[i][0]);
      end
      // Powered down: pins released, calibration request ignored
      power_down_pin <= 1'b1;
      repeat (60) @(posedge aclk);
      chk(data_bus_oe, 1'b0);
      cal_request_pin <= 1'b1;
      repeat (60) @(posedge aclk);
      cal_request_pin <= 1'b0;
      repeat (600) @(posedge aclk);
      st(32'h00000012);
      power_down_pin <= 1'b0;
      repeat (60) @(posedge aclk);
      st(32'h0000000c);
      chk(data_bus_oe, 1'b1);
      // Power-down in mid-calibration waits for its end
      cal_request_pin <= 1'b1;
      repeat (20) @(posedge aclk);
      {power_down_pin, cal_request_pin} <= 2'h2;
      repeat (100) @(posedge aclk);
      st(32'h00000009);
      repeat (450) @(posedge aclk);
      st(32'h00000012);
      // Unmapped place and read-only status
      wr(8'h08, 32'h7);
      chk(rsp, 32'h2);
      rd(8'h08);
      chk(d, 32'h0);
      chk(rsp, 32'h2);
      wr(8'h04, 32'h0);
      chk(rsp, 32'h0);
      st(32'h00000012);
      // Second reset with power-down high
      aresetn <= 1'b0;
      repeat (80) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (400) @(posedge aclk);
      st(32'h00000002);
      chk(analog_enable, 1'b0);
      rd(8'h00);
      chk(d, 32'h1);
      power_down_pin <= 1'b0;
      repeat (800) @(posedge aclk);
      st(32'h0000000c);
      complete_run;
   end
endmodule : adm_output_ctrl_tb_top
`default_nettype wire
